// *** logic/keypad_regs.svh ***
`ifndef KEYPAD_REGS_SVH
`define KEYPAD_REGS_SVH

// register indices; byte address is four times the index
`define COLUMN_RESULT_IDX 8'hD1
`define ROW_RESULT_IDX 8'hD2
`define KEYPAD_TIMING_IDX 8'hD3
`define KEYPAD_CONTROL_STATUS_IDX 8'hD4
`define IRQ_STATUS_IDX 8'hD8
`define IRQ_MASK_IDX 8'hD9
`define KEY_SETUP_IDX 8'hDA

// reset values
`define KEYPAD_TIMING_RST 8'h00
`define KEYPAD_CONTROL_STATUS_RST 8'h00
`define COLUMN_RESULT_RST 5'h1F
`define ROW_RESULT_RST 6'h3F
`define IRQ_RST 3'h0
`define KEY_SETUP_RST 1'h0

// keypad_timing fields
`define SCAN_STEP_LSB 0
`define SCAN_STEP_MSB 1
`define DEBOUNCE_LSB 2
`define DEBOUNCE_MSB 7

// keypad_control_status fields
`define KEY_DETECT_IRQ_EN_BIT 0
`define KEY_DETECT_FLAG_BIT 1
`define AUTO_SCAN_EN_BIT 2
`define KEY_CLOCK_STATE_BIT 3

// irq status / mask bits
`define EV_VALID_KEY 0
`define EV_INVALID_KEY 1
`define EV_RELEASE 2

// timing
`define PCLK_PERIOD_NS 100
`define KEY_TICK_NS 1000000
`define DEBOUNCE_UNIT_MS 4
`define DEBOUNCE_ZERO_UNITS 7'h40
`define STEP_CODE_1MS 2'h1
`define STEP_CODE_2MS 2'h2
`define STEP_CODE_3MS 2'h0
`define STEP_CODE_4MS 2'h3
`define LAST_COL 3'h4
`define LAST_ROW 3'h5

`endif

// *** logic/keypad_pkg.sv ***
package keypad_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PRESS_DB = 3'b001,
      ST_SCAN = 3'b010,
      ST_WAIT_REL = 3'b011,
      ST_REL_DB = 3'b100
   } scan_state_t;

   typedef struct packed {
      logic [7:0] timing;
      logic auto_en;
      logic irq_en;
      logic flag;
      logic clk_en;
      logic [4:0] col_res;
      logic [5:0] row_res;
      logic [2:0] irq_sts;
      logic [2:0] irq_mask;
   } regs_t;

   typedef struct packed {
      regs_t r;
      logic [13:0] div;
      logic key_clk;
      logic tick;
      logic [5:0] row_s1;
      logic [5:0] row_s2;
      logic all_high_prev;
      scan_state_t st;
      logic [8:0] tcnt;
      logic [2:0] col_idx;
      logic [2:0] row_idx;
      logic [1:0] hits;
      logic [2:0] hit_col;
      logic [2:0] hit_row;
      logic [4:0] col_out;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;

endpackage

// *** logic/keypad_scan_timing_status.sv ***
`timescale 1ns/1ps
`include "keypad_regs.svh"
// How it works
// - The debounce period is the six-bit field times 4 ms, with 0 meaning 256 ms.
// - The same debounce period is applied to presses and to releases.
// - Successive key checks in a scan are spaced by the two-bit scan step code (01 = 1 ms, 10 = 2 ms).
// - Reading the control/status register returns the present keypad clock level in bit 3.
// - With auto-scan set the block scans by itself; with it clear columns follow the column register.
// - In auto-scan a single valid press sets the key-detect flag and loads column and row results.
// - In bypass mode a falling row after all rows high sets the key-detect flag, bounce included.
// - Reading the control/status register clears the key-detect flag in both modes.
// - In bypass mode detection works even when the keypad clock is stopped.
// - The flag raises the interrupt only while its enable bit is set, but is set regardless.
// - If no row is still low after the press debounce, the block goes back to waiting.
// - Two or more keys found in one scan are invalid and no location is reported.
module keypad_scan_timing_status
   import keypad_pkg::*;
#(
   parameter int KEY_CLK_HALF = `KEY_TICK_NS / `PCLK_PERIOD_NS / 2
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // keypad matrix
   input wire logic [5:0] row_in,
   output logic [4:0] col_out,
   // interrupt
   output logic irq
);

   state_t q, d;

   logic access, wr, rd;
   logic [9:0] idx;
   logic [6:0] db_units;
   logic [8:0] db_ticks;
   logic [8:0] step_ticks;
   logic any_low, all_high, row_hit;
   logic [2:0] ev;
   logic flag_set;

   assign access = psel & penable & q.pready;
   assign wr = access & pwrite & ~q.pslverr;
   assign rd = access & ~pwrite & ~q.pslverr;
   assign idx = paddr[11:2];

   always_comb begin
      // 0 is the longest debounce, not the shortest
      db_units = (q.r.timing[`DEBOUNCE_MSB:`DEBOUNCE_LSB] == 6'h00) ? `DEBOUNCE_ZERO_UNITS
                 : {1'b0, q.r.timing[`DEBOUNCE_MSB:`DEBOUNCE_LSB]};
      db_ticks = 9'(db_units) * 9'(`DEBOUNCE_UNIT_MS);
      case (q.r.timing[`SCAN_STEP_MSB:`SCAN_STEP_LSB])
         `STEP_CODE_1MS: step_ticks = 9'h001;
         `STEP_CODE_2MS: step_ticks = 9'h002;
         `STEP_CODE_3MS: step_ticks = 9'h003;
         `STEP_CODE_4MS: step_ticks = 9'h004;
         default: step_ticks = 9'h001;
      endcase
   end

   always_comb begin
      d = q;
      ev = 3'h0;
      flag_set = 1'b0;
      any_low = ~&q.row_s2;
      all_high = &q.row_s2;
      row_hit = ~q.row_s2[q.row_idx];

      // 1 kHz keypad clock from the bus clock; tick on its rising edge
      d.tick = 1'b0;
      if (q.r.clk_en) begin
         if (q.div == 14'(KEY_CLK_HALF - 1)) begin
            d.div = 14'h0000;
            d.key_clk = ~q.key_clk;
            d.tick = ~q.key_clk;
         end else begin
            d.div = q.div + 14'h0001;
         end
      end

      // only the second stage is read by any logic
      d.row_s1 = row_in;
      d.row_s2 = q.row_s1;
      d.all_high_prev = all_high;

      if (q.r.auto_en) begin
         case (q.st)
            ST_IDLE: begin
               d.col_out = 5'h00;
               d.tcnt = 9'h000;
               if (any_low) begin
                  d.st = ST_PRESS_DB;
               end
            end
            ST_PRESS_DB: begin
               if (q.tick) begin
                  d.tcnt = q.tcnt + 9'h001;
               end
               if (q.tick && q.tcnt == db_ticks - 9'h001) begin
                  d.tcnt = 9'h000;
                  if (any_low) begin
                     d.st = ST_SCAN;
                     d.col_idx = 3'h0;
                     d.row_idx = 3'h0;
                     d.hits = 2'h0;
                     d.col_out = 5'h1E;
                  end else begin
                     d.st = ST_IDLE;
                  end
               end
            end
            ST_SCAN: begin
               if (q.tick) begin
                  d.tcnt = q.tcnt + 9'h001;
               end
               if (q.tick && q.tcnt == step_ticks - 9'h001) begin
                  d.tcnt = 9'h000;
                  if (row_hit) begin
                     d.hits = (q.hits == 2'h2) ? 2'h2 : q.hits + 2'h1;
                     d.hit_col = q.col_idx;
                     d.hit_row = q.row_idx;
                  end
                  if (q.row_idx == `LAST_ROW) begin
                     d.row_idx = 3'h0;
                     d.col_idx = q.col_idx + 3'h1;
                     d.col_out = ~(5'h01 << (q.col_idx + 3'h1));
                  end else begin
                     d.row_idx = q.row_idx + 3'h1;
                  end
                  if (q.row_idx == `LAST_ROW && q.col_idx == `LAST_COL) begin
                     d.st = ST_WAIT_REL;
                     d.col_out = 5'h00;
                     if (d.hits == 2'h1) begin
                        flag_set = 1'b1;
                        ev[`EV_VALID_KEY] = 1'b1;
                        d.r.col_res = ~(5'h01 << d.hit_col);
                        d.r.row_res = ~(6'h01 << d.hit_row);
                     end else begin
                        ev[`EV_INVALID_KEY] = 1'b1;
                     end
                  end
               end
            end
            ST_WAIT_REL: begin
               d.col_out = 5'h00;
               d.tcnt = 9'h000;
               if (all_high) begin
                  d.st = ST_REL_DB;
               end
            end
            ST_REL_DB: begin
               // any low row restarts the release debounce
               if (any_low) begin
                  d.tcnt = 9'h000;
               end else if (q.tick) begin
                  d.tcnt = q.tcnt + 9'h001;
                  if (q.tcnt == db_ticks - 9'h001) begin
                     d.st = ST_IDLE;
                     ev[`EV_RELEASE] = 1'b1;
                  end
               end
            end
            default: d.st = ST_IDLE;
         endcase
      end else begin
         // bypass: software drives columns and reads live rows
         d.st = ST_IDLE;
         d.tcnt = 9'h000;
         d.col_out = q.r.col_res;
         d.r.row_res = q.row_s2;
         // needs no keypad clock tick, so works with it stopped
         if (q.all_high_prev && any_low) begin
            flag_set = 1'b1;
         end
      end

      // register writes take effect at the completing edge
      if (wr) begin
         case (idx)
            10'(`KEYPAD_TIMING_IDX): d.r.timing = pwdata[7:0];
            10'(`KEYPAD_CONTROL_STATUS_IDX): begin
               d.r.auto_en = pwdata[`AUTO_SCAN_EN_BIT];
               d.r.irq_en = pwdata[`KEY_DETECT_IRQ_EN_BIT];
            end
            10'(`COLUMN_RESULT_IDX): d.r.col_res = pwdata[4:0];
            10'(`IRQ_MASK_IDX): d.r.irq_mask = pwdata[2:0];
            10'(`KEY_SETUP_IDX): d.r.clk_en = pwdata[0];
            default: d.r = d.r;
         endcase
      end

      // set wins over clear-on-read and write-one-to-clear
      d.r.flag = (q.r.flag & ~(rd && idx == 10'(`KEYPAD_CONTROL_STATUS_IDX))) | flag_set;
      d.r.irq_sts = q.r.irq_sts;
      if (wr && idx == 10'(`IRQ_STATUS_IDX)) begin
         d.r.irq_sts = q.r.irq_sts & ~pwdata[2:0];
      end
      d.r.irq_sts = d.r.irq_sts | ev;
      d.irq = (d.r.flag & d.r.irq_en) | (|(d.r.irq_sts & d.r.irq_mask));

      // one wait state: pready rises in the second access cycle
      d.pready = psel & penable & ~q.pready;
      // the error flag stands only alongside pready, never into the next transfer
      d.pslverr = 1'b0;
      if (psel && penable && !q.pready) begin
         d.prdata = 32'h0000_0000;
         case (idx)
            10'(`KEYPAD_TIMING_IDX): d.prdata[7:0] = q.r.timing;
            10'(`KEYPAD_CONTROL_STATUS_IDX): begin
               d.prdata[`KEY_CLOCK_STATE_BIT] = q.key_clk;
               d.prdata[`AUTO_SCAN_EN_BIT] = q.r.auto_en;
               d.prdata[`KEY_DETECT_FLAG_BIT] = q.r.flag | flag_set;
               d.prdata[`KEY_DETECT_IRQ_EN_BIT] = q.r.irq_en;
            end
            10'(`COLUMN_RESULT_IDX): d.prdata[4:0] = q.r.col_res;
            10'(`ROW_RESULT_IDX): d.prdata[5:0] = q.r.row_res;
            10'(`IRQ_STATUS_IDX): d.prdata[2:0] = q.r.irq_sts;
            10'(`IRQ_MASK_IDX): d.prdata[2:0] = q.r.irq_mask;
            10'(`KEY_SETUP_IDX): d.prdata[0] = q.r.clk_en;
            default: d.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.r.timing <= `KEYPAD_TIMING_RST;
         q.r.auto_en <= 1'b0;
         q.r.irq_en <= 1'b0;
         q.r.flag <= 1'b0;
         q.r.clk_en <= `KEY_SETUP_RST;
         q.r.col_res <= `COLUMN_RESULT_RST;
         q.r.row_res <= `ROW_RESULT_RST;
         q.r.irq_sts <= `IRQ_RST;
         q.r.irq_mask <= `IRQ_RST;
         q.div <= 14'h0000;
         q.key_clk <= 1'b0;
         q.tick <= 1'b0;
         q.row_s1 <= 6'h3F;
         q.row_s2 <= 6'h3F;
         q.all_high_prev <= 1'b1;
         q.st <= ST_IDLE;
         q.tcnt <= 9'h000;
         q.col_idx <= 3'h0;
         q.row_idx <= 3'h0;
         q.hits <= 2'h0;
         q.hit_col <= 3'h0;
         q.hit_row <= 3'h0;
         q.col_out <= `COLUMN_RESULT_RST;
         q.irq <= 1'b0;
         q.pready <= 1'b0;
         q.pslverr <= 1'b0;
         q.prdata <= 32'h0000_0000;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign col_out = q.col_out;
   assign irq = q.irq;

endmodule

// *** tb/keypad_matrix.sv ***
`timescale 1ns/1ps
module keypad_matrix (
   // column drive from the block, low selects
   input wire logic [4:0] col_out,
   // closed switches, bit col*6+row
   input wire logic [29:0] keys,
   // rows have pull-ups, so an open matrix reads all high
   output logic [5:0] row_in
);
   always_comb begin
      row_in = 6'h3F;
      for (int k = 0; k < 30; k++) begin
         if (keys[k] && !col_out[k / 6]) row_in[k % 6] = 1'b0;
      end
   end
endmodule

// *** tb/keypad_props.sv ***
`timescale 1ns/1ps
module keypad_props (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // keypad and interrupt
   input wire logic [5:0] row_in,
   input wire logic [4:0] col_out,
   input wire logic irq
);
   wire logic [9:0] idx = paddr[11:2];
   wire logic done = psel && penable && pready;
   wire logic rd_ctl = done && !pwrite && idx == 10'h0D4;
   logic auto_q, en_q;
   logic [2:0] mask_q;
   // mode bits rebuilt from completed writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_q <= 1'b0;
         en_q <= 1'b0;
         mask_q <= 3'h0;
      end else begin
         if (done && pwrite && idx == 10'h0D4) begin
            auto_q <= pwdata[2];
            en_q <= pwdata[0];
         end
         if (done && pwrite && idx == 10'h0D9) mask_q <= pwdata[2:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_ready_late: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_err_map: assert property (done |-> pslverr == !(idx inside {10'h0D1, 10'h0D2,
      10'h0D3, 10'h0D4, 10'h0D8, 10'h0D9, 10'h0DA})) else $error("pslverr wrong");
   a_err_data: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
   a_err_ready: assert property (pslverr |-> pready) else $error("pslverr outside pready");
   a_read_upper: assert property (done && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_bypass_cols:
      assert property (!auto_q && done && pwrite && idx == 10'h0D1 |=> ##1
         col_out == $past(pwdata[4:0], 2)) else $error("columns ignore register");
   a_irq_gate:
      assert property (!en_q && mask_q == 3'h0 && !$past(en_q) && $past(mask_q) == 3'h0
         |-> !irq) else $error("irq while disabled");
   a_detect_bypass:
      assert property (!auto_q && en_q && $past(row_in) == 6'h3F && row_in != 6'h3F
         |-> ##[1:5] irq) else $error("row fall not flagged");
   a_flag_clear:
      assert property (!auto_q && mask_q == 3'h0 && rd_ctl && $stable(row_in) &&
         $past(row_in, 3) == row_in |=> ##1 !irq) else $error("flag not cleared");
   c_err: cover property (done && pslverr);
   c_bypass_irq: cover property (!auto_q && irq);
   c_auto_read: cover property (auto_q && done && !pwrite && idx == 10'h0D1);
endmodule
bind keypad_scan_timing_status keypad_props keypad_props_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .row_in(row_in),
   .col_out(col_out), .irq(irq));

// *** tb/keypad_scan_timing_status_tb.sv ***
`timescale 1ns/1ps
module keypad_scan_timing_status_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [29:0] keys = 30'h0;
   logic [5:0] row_in;
   logic [4:0] col_out;
   logic pready, pslverr, irq, rerr;
   logic [7:0] tv;
   int fails = 0, n_checks = 0, n, e, d, k;
   always #50 pclk = ~pclk;
   keypad_scan_timing_status #(.KEY_CLK_HALF(4)) keypad_scan_timing_status_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .row_in(row_in), .col_out(col_out), .irq(irq));
   keypad_matrix keypad_matrix_i (.col_out(col_out), .keys(keys), .row_in(row_in));
   task automatic test_done;
      if (fails == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tmo;
      fails++;
      test_done();
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) fails++;
      if (s !== x) $display("ERROR at %0t: seen %h expected %h", $time, s, x);
   endtask
   task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd);
      int t;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 2'h0, ix, 2'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      for (t = 0; t < 20 && pready !== 1'b1; t++) @(posedge pclk);
      if (t == 20) tmo();
      rdat = prdata;
      rerr = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] ix, input logic [31:0] wd);
      apb(1'b1, ix, wd);
   endtask
   task automatic rchk(input logic [7:0] ix, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, ix, 32'h0);
      chk(rdat & m, x);
   endtask
   task automatic wirq(input int lim);
      for (n = 0; n < lim && irq !== 1'b1; n++) @(posedge pclk);
      if (n == lim) tmo();
   endtask
   // one ms is eight pclk with the shortened keypad clock
   function automatic int ms(input logic [1:0] c);
      return (c == 2'h1) ? 1 : (c == 2'h2) ? 2 : (c == 2'h0) ? 3 : 4;
   endfunction
   task automatic akey(input logic [5:0] db, input logic [1:0] sc);
      k = $urandom_range(29);
      d = (db == 6'h0) ? 256 : 4 * db;
      e = d + 30 * ms(sc);
      wr(8'hD3, {24'h0, db, sc});
      keys <= 30'h1 << k;
      wirq(e * 8 + 200);
      // tick phase is free, so allow two ms either side
      chk({31'h0, n >= (e - 2) * 8 && n <= (e + 2) * 8}, 32'h1);
      rchk(8'hD1, 32'hFF, {27'h0, ~(5'h01 << (k / 6))});
      rchk(8'hD2, 32'hFF, {26'h0, ~(6'h01 << (k % 6))});
      rchk(8'hD4, 32'hF7, 32'h7);
      rchk(8'hD4, 32'hF7, 32'h5);
      wr(8'hD8, 32'h4);
      keys <= 30'h0;
      // release event must wait for the whole debounce period
      repeat ((d - 2) * 8) @(posedge pclk);
      rchk(8'hD8, 32'h4, 32'h0);
      repeat (48) @(posedge pclk);
      rchk(8'hD8, 32'h4, 32'h4);
   endtask
   initial begin
      void'($urandom(32'hAC2E));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(8'hD3, 32'hFFFFFFFF, 32'h0);
      rchk(8'hD4, 32'hFFFFFFFF, 32'h0);
      tv = 8'($urandom);
      wr(8'hD3, {24'h0, tv});
      rchk(8'hD3, 32'hFFFFFFFF, {24'h0, tv});
      rchk(8'hD5, 32'hFFFFFFFF, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      // bypass with the keypad clock stopped
      wr(8'hD4, 32'h1);
      wr(8'hD1, 32'h1E);
      repeat (2) @(posedge pclk);
      chk({27'h0, col_out}, 32'h1E);
      k = $urandom_range(5);
      keys <= 30'h1 << k;
      wirq(20);
      rchk(8'hD2, 32'hFF, {26'h0, ~(6'h01 << k)});
      rchk(8'hD4, 32'hFF, 32'h3);
      rchk(8'hD4, 32'hFF, 32'h1);
      keys <= 30'h0;
      wr(8'hD4, 32'h0);
      keys <= 30'h1 << k;
      repeat (8) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rchk(8'hD4, 32'hFF, 32'h2);
      keys <= 30'h0;
      wr(8'hDA, 32'h1);
      tv = 8'h0;
      repeat (16) begin
         apb(1'b0, 8'hD4, 32'h0);
         tv[rdat[3]] = 1'b1;
      end
      chk({24'h0, tv}, 32'h3);
      wr(8'hD4, 32'h5);
      for (int s = 0; s < 4; s++) akey(6'($urandom_range(3, 1)), 2'(s));
      akey(6'h0, 2'h1);
      rchk(8'hD8, 32'hFF, 32'h5);
      wr(8'hD9, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      wr(8'hD8, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(8'hD9, 32'h0);
      wr(8'hD8, 32'h7);
      // a press shorter than the debounce must be dropped
      wr(8'hD3, 32'h11);
      keys <= 30'h1;
      repeat (40) @(posedge pclk);
      keys <= 30'h0;
      repeat (200) @(posedge pclk);
      rchk(8'hD4, 32'h2, 32'h0);
      rchk(8'hD8, 32'hFF, 32'h0);
      k = $urandom_range(29);
      keys <= (30'h1 << k) | (30'h1 << ((k + 7) % 30));
      repeat (400) @(posedge pclk);
      rchk(8'hD4, 32'h2, 32'h0);
      rchk(8'hD8, 32'h2, 32'h2);
      // reset in mid-run with keys still held: everything back to reset values
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(8'hD1, 32'hFFFFFFFF, 32'h1F);
      rchk(8'hD2, 32'hFFFFFFFF, 32'h3F);
      rchk(8'hD4, 32'hFFFFFFFF, 32'h0);
      rchk(8'hD8, 32'hFFFFFFFF, 32'h0);
      rchk(8'hDA, 32'hFFFFFFFF, 32'h0);
      chk({27'h0, col_out}, 32'h1F);
      chk({31'h0, irq}, 32'h0);
      test_done();
   end
endmodule
